// >>> hdl/fspg_consts.svh
// Purpose: constants for the flash self-program guard
// Assumes: word addressed flash, 16-bit word address
// Notes: offsets are byte addresses on the register bus
`ifndef FSPG_CONSTS_SVH
`define FSPG_CONSTS_SVH
`define FSPG_AW 16
`define FSPG_PAGE_LSB 7
`define FSPG_HALT_START 16'hf000
`define FSPG_REG_CTRL 8'h00
`define FSPG_REG_LOCK 8'h04
`define FSPG_REG_STAT 8'h08
`define FSPG_REG_FUSE 8'h0c
`define FSPG_CTRL_RST 8'h00
`define FSPG_LOCK_RST 4'hf
`define FSPG_FUSE_RST 2'h0
`define FSPG_SPM_WIN 3'h4
`define FSPG_PROG_T_US 4000
`define FSPG_CLK_MHZ 10
`define FSPG_PROG_CYC (`FSPG_PROG_T_US * `FSPG_CLK_MHZ)
`define FSPG_WB_OK 2'h0
`define FSPG_WB_ERR 2'h2
`endif

// >>> hdl/fspg_pkg.sv
// Purpose: types for the flash self-program guard
// Assumes: fspg_consts.svh defines widths
// Notes: none
`include "fspg_consts.svh"
package fspg_pkg;
  typedef enum logic [1:0] {
    FSPG_OP_NONE, FSPG_OP_BUF, FSPG_OP_ERASE, FSPG_OP_WRITE
  } fspg_op_t;
  typedef struct packed {
    logic store;
    logic load;
    logic fetch;
    logic [`FSPG_AW-1:0] pc;
    logic [`FSPG_AW-1:0] z;
  } fspg_cpu_req_t;
  typedef struct packed {
    logic stall;
    logic load_ok;
    logic store_go;
    fspg_op_t op;
    logic [`FSPG_AW-1:0] page;
    logic irq_block;
    logic rww_bad;
  } fspg_cpu_rsp_t;
endpackage

// >>> hdl/fspg_top.sv
// Purpose: flash self-program access guard with AXI4-Lite registers
// Assumes: CPU request struct is synchronous to sys_clk
// Notes: flash macro busy is counted here by a program-time counter
// Functional notes
// - Store ignored when fetched from application
// - Boot-part store may target any page
// - Boundary from fuses; per-part lock pair
// - Concurrent-part program keeps CPU running
// - Halting-part program stalls CPU throughout
// - Halt depends on target page only
// - Boot part always inside halting part
// - Busy flag one while concurrent blocked
// - Two independent lock pairs held
// - Locks only program to 0; chip erase restores
// - General lock modes do not restrict
// - Application mode 1 unrestricted
// - Application modes 2,3 block store
// - Application modes 3,4 block boot loads
// - Application modes 3,4 mask application irqs
// - Boot mode 1 unrestricted
// - Boot modes 2,3 block store
// - Boot modes 3,4 block application loads
// - Boot modes 3,4 mask boot irqs
// - Lock bit 1 unprogrammed, 0 programmed
// - Busy set on concurrent-part program start
// - Reenable with enable, store within four
// - Target page from upper Z bits
`timescale 1ns/1ps
`include "fspg_consts.svh"
module fspg_top #(
  parameter int PROG_CYC = `FSPG_PROG_CYC
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire fspg_pkg::fspg_cpu_req_t cpu_req,
  output fspg_pkg::fspg_cpu_rsp_t cpu_rsp,
  input wire logic chip_erase,
  input wire logic ivec_in_boot,
  input wire logic general_lock_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import fspg_pkg::*;

  // Control bits: [4] reenable [2] write [1] erase [0] enable
  logic [7:0] ctrl_reg;
  logic [3:0] lock_reg;
  logic [1:0] fuse_reg;
  logic busy_reg;
  logic halt_tgt_reg;
  logic [31:0] prog_cnt_reg;
  logic [2:0] win_reg;
  logic [7:0] aw_addr_reg;
  logic aw_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_have_reg;
  logic [`FSPG_AW-1:0] boot_start;
  logic pc_boot, z_boot, z_halt, pc_halt_ok;
  logic app_store_ok, app_load_ok, boot_store_ok, boot_load_ok;
  logic store_ok, load_ok, store_go, prog_busy, wr_fire;
  fspg_op_t op;

  // Boot part start from fuses: 512..4K words from top
  always_comb begin
    unique case (fuse_reg)
      2'h0: boot_start = 16'hf000;
      2'h1: boot_start = 16'hf800;
      2'h2: boot_start = 16'hfc00;
      default: boot_start = 16'hfe00;
    endcase
  end

  // Part decode; fuse range never starts below halting start
  assign pc_boot = cpu_req.pc >= boot_start;
  assign z_boot = cpu_req.z >= boot_start;
  assign z_halt = cpu_req.z >= `FSPG_HALT_START;
  assign pc_halt_ok = cpu_req.pc >= `FSPG_HALT_START;

  // Lock decode, 0 means programmed; general lock unused here
  assign app_store_ok = lock_reg[0];
  assign app_load_ok = lock_reg[1] || !pc_boot;
  assign boot_store_ok = lock_reg[2];
  assign boot_load_ok = lock_reg[3] || pc_boot;

  assign store_ok = pc_boot &&
    (z_boot ? boot_store_ok : app_store_ok);
  assign load_ok = z_boot ? boot_load_ok : app_load_ok;
  assign prog_busy = prog_cnt_reg != 32'h0;

  // Armed command picks the operation
  always_comb begin
    op = FSPG_OP_NONE;
    if (ctrl_reg[2])
      op = FSPG_OP_WRITE;
    else if (ctrl_reg[1])
      op = FSPG_OP_ERASE;
    else if (!ctrl_reg[4])
      op = FSPG_OP_BUF;
  end

  // Forbidden store starts nothing
  assign store_go = cpu_req.store && win_reg != 3'h0 &&
    store_ok && !prog_busy;

  // Program-time counter for erase or write
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prog_cnt_reg <= 32'h0;
    end else if (store_go &&
        (op == FSPG_OP_ERASE || op == FSPG_OP_WRITE)) begin
      prog_cnt_reg <= 32'(PROG_CYC);
    end else if (prog_busy) begin
      prog_cnt_reg <= prog_cnt_reg - 32'h1;
    end
  end

  // Target part latched at launch; Z may move while the flash works
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      halt_tgt_reg <= 1'b0;
    end else if (store_go &&
        (op == FSPG_OP_ERASE || op == FSPG_OP_WRITE)) begin
      halt_tgt_reg <= z_halt;
    end
  end

  // Busy flag: set wins over reenable clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg <= 1'b0;
    end else if (store_go && !z_halt &&
        (op == FSPG_OP_ERASE || op == FSPG_OP_WRITE)) begin
      busy_reg <= 1'b1;
    end else if (cpu_req.store && win_reg != 3'h0 && pc_boot &&
        ctrl_reg[4] && !prog_busy) begin
      busy_reg <= 1'b0;
    end
  end

  // Store enable window of four cycles
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      win_reg <= 3'h0;
      ctrl_reg <= `FSPG_CTRL_RST;
    end else if (wr_fire && aw_addr_reg == `FSPG_REG_CTRL &&
        w_strb_reg[0] && w_data_reg[0] && !prog_busy) begin
      win_reg <= `FSPG_SPM_WIN;
      ctrl_reg <= {3'h0, w_data_reg[4:0]};
    end else if (cpu_req.store && win_reg != 3'h0) begin
      win_reg <= 3'h0;
      ctrl_reg <= `FSPG_CTRL_RST;
    end else if (win_reg != 3'h0) begin
      win_reg <= win_reg - 3'h1;
      if (win_reg == 3'h1)
        ctrl_reg <= `FSPG_CTRL_RST;
    end
  end

  // Locks only clear to 0 by software; chip erase sets all
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_reg <= `FSPG_LOCK_RST;
    end else if (chip_erase) begin
      lock_reg <= `FSPG_LOCK_RST;
    end else if (wr_fire && aw_addr_reg == `FSPG_REG_LOCK &&
        w_strb_reg[0]) begin
      lock_reg <= lock_reg & w_data_reg[3:0];
    end
  end

  // Fuses stand for the programmer port
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fuse_reg <= `FSPG_FUSE_RST;
    end else if (wr_fire && aw_addr_reg == `FSPG_REG_FUSE &&
        w_strb_reg[0]) begin
      fuse_reg <= w_data_reg[1:0];
    end
  end

  // CPU response, registered; page from upper Z bits
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_rsp <= '0;
    end else begin
      cpu_rsp.stall <= prog_busy && halt_tgt_reg;
      cpu_rsp.load_ok <= cpu_req.load && load_ok;
      cpu_rsp.store_go <= store_go;
      cpu_rsp.op <= store_go ? op : FSPG_OP_NONE;
      cpu_rsp.page <= {cpu_req.z[`FSPG_AW-1:`FSPG_PAGE_LSB],
        {`FSPG_PAGE_LSB{1'b0}}};
      cpu_rsp.irq_block <=
        (!lock_reg[1] && ivec_in_boot && !pc_boot) ||
        (!lock_reg[3] && !ivec_in_boot && pc_boot);
      cpu_rsp.rww_bad <= busy_reg &&
        ((cpu_req.fetch && !pc_halt_ok) ||
         (cpu_req.load && !z_halt));
    end
  end

  // AXI write side: address and data in either order
  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FSPG_WB_OK;
    end else begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready &&
        s_axi_awvalid;
      s_axi_wready <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg == `FSPG_REG_CTRL ||
          aw_addr_reg == `FSPG_REG_LOCK ||
          aw_addr_reg == `FSPG_REG_FUSE) ? `FSPG_WB_OK : `FSPG_WB_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read side; status shows general lock, halt, program busy and busy
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `FSPG_WB_OK;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
        s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `FSPG_WB_OK;
        unique case ({s_axi_araddr[7:2], 2'h0})
          `FSPG_REG_CTRL: s_axi_rdata <= {24'h0, 1'b0, busy_reg,
            1'b0, ctrl_reg[4:1], prog_busy || win_reg != 3'h0};
          `FSPG_REG_LOCK: s_axi_rdata <= {28'h0, lock_reg};
          `FSPG_REG_STAT: s_axi_rdata <= {28'h0, general_lock_n,
            prog_busy && halt_tgt_reg, prog_busy, busy_reg};
          `FSPG_REG_FUSE: s_axi_rdata <= {30'h0, fuse_reg};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `FSPG_WB_ERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// >>> verification/fspg_checker.sv
// Purpose: temporal checks on the guard's ports
// Assumes: bound to every fspg_top instance
// Notes: halting part starts at word 16'hf000
`timescale 1ns/1ps
module fspg_checker (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire fspg_pkg::fspg_cpu_req_t cpu_req,
  input wire fspg_pkg::fspg_cpu_rsp_t cpu_rsp,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Read handshake steps
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence r_held;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  a_app_store_dead: assert property (
    cpu_req.store && cpu_req.pc < 16'hf000 |=> !cpu_rsp.store_go)
    else $error("store from application accepted");
  a_go_has_cause: assert property (
    cpu_rsp.store_go |-> $past(cpu_req.store)) else $error("stray store");
  a_page_from_z: assert property (
    cpu_rsp.store_go |-> cpu_rsp.page == {$past(cpu_req.z[15:7]), 7'h0})
    else $error("page not from z");
  a_stall_halt_only: assert property (
    cpu_rsp.stall |-> $past(cpu_req.z) >= 16'hf000) else $error("bad stall");
  a_stall_holds: assert property (
    $rose(cpu_rsp.stall) |-> cpu_rsp.stall[*4]) else $error("short stall");
  a_load_cause: assert property (
    cpu_rsp.load_ok |-> $past(cpu_req.load)) else $error("stray load");
  a_rww_bad_cause: assert property (
    cpu_rsp.rww_bad |-> $past(cpu_req.fetch || cpu_req.load))
    else $error("stray concurrent-part flag");
  a_hole_refused: assert property (
    ar_taken ##0 s_axi_araddr > 8'h0c |=> s_axi_rresp == 2'h2 &&
    s_axi_rdata == 32'h0) else $error("hole read not refused");
  a_rdata_stands: assert property (
    r_held |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule
bind fspg_top fspg_checker chk (.*);

// >>> verification/fspg_cpu_model.sv
// Purpose: CPU core stand-in issuing store and load requests
// Assumes: bench sets the wanted request by non-blocking writes
// Notes: passes requests straight through, so no added latency
`timescale 1ns/1ps
module fspg_cpu_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire fspg_pkg::fspg_cpu_req_t want,
  input wire fspg_pkg::fspg_cpu_rsp_t cpu_rsp,
  output fspg_pkg::fspg_cpu_req_t cpu_req
);
  import fspg_pkg::*;
  logic busy_reg;
  // Concurrent part busy until a store that is no concurrent-part program
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg <= 1'b0;
    end else if (cpu_rsp.store_go) begin
      busy_reg <= cpu_rsp.op inside {FSPG_OP_ERASE, FSPG_OP_WRITE} &&
        cpu_rsp.page < 16'hf000;
    end
  end
  // Halted core issues no store; careful loader drops all loads and fetches while busy
  always_comb begin
    cpu_req = want;
    if (cpu_rsp.stall) cpu_req.store = 1'b0;
    if (busy_reg) begin
      cpu_req.load = 1'b0;
      cpu_req.fetch = 1'b0;
    end
  end
endmodule

// >>> verification/test_flash_self_program_guard.sv
// Purpose: self-checking bench for the flash self-program guard
// Assumes: program time cut to 8 cycles
// Notes: read data and CPU answers are matched from queues
`timescale 1ns/1ps
module test_flash_self_program_guard;
  import fspg_pkg::*;
  localparam int PC = 8;
  logic sys_clk = 0, arst_n = 0, chip_erase = 0, ivec_in_boot = 0;
  logic general_lock_n = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, due = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] r;
  fspg_cpu_req_t want = '0, cpu_req;
  fspg_cpu_rsp_t cpu_rsp;
  logic [31:0] rq[$];
  logic [2:0] cq[$];
  int err_count = 0, n_tests = 0, scnt = 0, s0;
  always #50 sys_clk = ~sys_clk;
  fspg_top #(.PROG_CYC(PC)) uut (.*);
  fspg_cpu_model cpu_m (.*);
  task automatic check(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Bus write; each channel released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge sys_clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 40);
    s_axi_bready <= 1'b0;
    if (n >= 40) begin err_count++; close_out(); end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    int n = 0;
    rq.push_back(e);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 40);
    s_axi_rready <= 1'b0;
    if (n >= 40) begin err_count++; close_out(); end
  endtask
  // One-cycle request; expected {go, ok, irq} noted
  task automatic cpu(input logic st, ld, input logic [15:0] p, z,
    input logic [2:0] e);
    @(posedge sys_clk);
    want <= '{store: st, load: ld, fetch: 1'b0, pc: p, z: z};
    cq.push_back(e);
    @(posedge sys_clk);
    {want.store, want.load} <= 2'h0;
  endtask
  task automatic prog(input logic [7:0] c, input logic [15:0] z,
    input logic go);
    wr(8'h00, {24'h0, c});
    cpu(1'b1, 1'b0, 16'hf100, z, {go, 2'h0});
    repeat (2 * PC + 4) @(posedge sys_clk);
  endtask
  // Watcher: answers land one edge after the request
  always @(posedge sys_clk) begin
    if (s_axi_rvalid && s_axi_rready) check(s_axi_rdata, rq.pop_front());
    if (due) check({cpu_rsp.store_go, cpu_rsp.load_ok,
      cpu_rsp.irq_block}, cq.pop_front());
    due <= cpu_req.store || cpu_req.load;
    if (cpu_rsp.stall) scnt++;
  end
  initial begin
    void'($urandom(40121));
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    general_lock_n <= 1'($urandom);
    rd(8'h04, 32'hf);
    rd(8'h10, 32'h0);
    $display("reset values done");
    wr(8'h00, 32'h5);
    cpu(1'b1, 1'b0, 16'h1000, 16'h2000, 3'h0);
    s0 = scnt;
    prog(8'h05, 16'h2080, 1'b1);
    check(scnt - s0, 0);
    rd(8'h08, {28'h0, general_lock_n, 3'h1});
    prog(8'h11, 16'h2080, 1'b1);
    rd(8'h08, {28'h0, general_lock_n, 3'h0});
    s0 = scnt;
    prog(8'h03, 16'hf080, 1'b1);
    check(scnt - s0, PC);
    $display("program sections done");
    wr(8'h04, 32'he);
    prog(8'h03, 16'h1000, 1'b0);
    prog(8'h03, 16'hf080, 1'b1);
    wr(8'h04, 32'hf);
    rd(8'h04, 32'he);
    chip_erase <= 1'b1;
    rd(8'h04, 32'hf);
    chip_erase <= 1'b0;
    wr(8'h04, 32'hb);
    prog(8'h05, 16'hf080, 1'b0);
    prog(8'h05, 16'h2000, 1'b1);
    prog(8'h11, 16'h2000, 1'b1);
    wr(8'h04, 32'h5);
    ivec_in_boot <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      r = 16'($urandom_range(16'hefff));
      cpu(1'b0, 1'b1, 16'hf100, r, 3'h0);
      cpu(1'b0, 1'b1, r, 16'hf100 + r[7:0], 3'h1);
      cpu(1'b0, 1'b1, r, r ^ 16'h1, 3'h3);
    end
    ivec_in_boot <= 1'b0;
    cpu(1'b0, 1'b1, 16'hf100, 16'hf200, 3'h3);
    $display("lock modes done");
    wr(8'h0c, 32'h3);
    rd(8'h0c, 32'h3);
    prog(8'h03, 16'hf080, 1'b0);
    $display("fuse boundary done");
    repeat (4) @(posedge sys_clk);
    close_out();
  end
endmodule
